// ---- hdl/psw_cfg.svh ----
`ifndef PSF_CFG_SVH
`define PSF_CFG_SVH
// Special function register address of the status word
`define PSF_SFR_ADDR     8'hd0
`define PSF_RESET_VAL    8'h00
// Read data shown while another register is addressed
`define PSF_RDATA_IDLE   8'h00
// Bank base after reset (bank zero)
`define PSF_BASE_RESET   5'h00
// Bit positions inside the status word
`define PSF_BIT_CARRY    7
`define PSF_BIT_AUX      6
`define PSF_BIT_USER0    5
`define PSF_BIT_BANK_HI  4
`define PSF_BIT_BANK_LO  3
`define PSF_BIT_OVFL     2
`define PSF_BIT_USER1    1
`define PSF_BIT_PARITY   0
// Bank base spacing in internal RAM (eight registers per bank)
`define PSF_BANK_SHIFT   3
`endif

// ---- hdl/psw_pkg.sv ----
`default_nettype none
package psf_pkg;
   // Operation class presented by the arithmetic unit with its flag strobe
   typedef enum logic [1:0] {
      PSF_OP_NONE,
      PSF_OP_ADDSUB,
      PSF_OP_MULDIV,
      PSF_OP_CARRY
   } psf_op_e;
endpackage
`default_nettype wire

// ---- hdl/psw_flags.sv ----
// Overview of operation
// - carry bit7 set on carry/borrow, else cleared
// - aux carry bit6 tracks nibble carry/borrow
// - bits 5 and 1 changed by software only
// - bits 4:3 select one of four banks
// - overflow bit2 from add/sub/mul/div results
// - parity bit0 is XOR of accumulator
// - word read/write at SFR 0xD0; a write of bit 0 is replaced by parity
`timescale 1ns/1ns
`default_nettype none
`include "psw_cfg.svh"
module psf_flags
(
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic              ce_i,
   // Special function register port
   input  wire logic        [7:0] sfr_addr_i,
   input  wire logic              sfr_wr_i,
   input  wire logic        [7:0] sfr_wdata_i,
   input  wire logic              sfr_bit_wr_i,
   input  wire logic        [2:0] sfr_bit_sel_i,
   input  wire logic              sfr_bit_val_i,
   output logic             [7:0] sfr_rdata_o,
   // Arithmetic unit flag update
   input  wire logic              alu_upd_i,
   input  wire psf_pkg::psf_op_e  alu_op_i,
   input  wire logic              alu_cy_i,
   input  wire logic              alu_ac_i,
   input  wire logic              alu_ov_i,
   input  wire logic        [7:0] acc_i,
   // Status outputs
   output logic             [7:0] program_status_word_o,
   output logic             [4:0] bank_base_o
);

   // Status word storage and its next value
   logic [7:0]       program_status_word;
   logic [7:0]       next_program_status_word;

   // Next values of the registered outputs
   logic [7:0]       next_sfr_rdata;
   logic [7:0]       next_word_copy;
   logic [4:0]       next_bank_base;

   // Decoded request qualifiers
   logic             addr_hit;
   logic             byte_wr;
   logic             bit_wr;
   psf_pkg::psf_op_e eff_op;

   // Address decode; a strobe aimed at any other register is ignored
   assign addr_hit = (sfr_addr_i == `PSF_SFR_ADDR);

   // Byte write wins when both strobes arrive in one cycle
   assign byte_wr  = addr_hit && sfr_wr_i;
   assign bit_wr   = addr_hit && sfr_bit_wr_i && !sfr_wr_i;

   // A low strobe turns whatever op code stands into no update,
   // so a stale op code left on the bus never touches the flags
   assign eff_op   = alu_upd_i ? alu_op_i : psf_pkg::PSF_OP_NONE;

   // Flag next state: software write first, arithmetic update on top
   always_comb
   begin
      next_program_status_word = program_status_word;
      if (byte_wr)
      begin
         next_program_status_word = sfr_wdata_i;
      end
      else if (bit_wr)
      begin
         next_program_status_word[sfr_bit_sel_i] = sfr_bit_val_i;
      end
      // Hardware update wins over a same-cycle software write of a flag;
      // the instruction that caused it retires after the write in program order
      unique case (eff_op)
         psf_pkg::PSF_OP_ADDSUB:
         begin
            next_program_status_word[`PSF_BIT_CARRY] = alu_cy_i;
            next_program_status_word[`PSF_BIT_AUX]   = alu_ac_i;
            next_program_status_word[`PSF_BIT_OVFL]  = alu_ov_i;
         end
         psf_pkg::PSF_OP_MULDIV:
         begin
            // No carry or nibble carry exists here, so both are cleared
            next_program_status_word[`PSF_BIT_CARRY] = 1'b0;
            next_program_status_word[`PSF_BIT_AUX]   = 1'b0;
            next_program_status_word[`PSF_BIT_OVFL]  = alu_ov_i;
         end
         psf_pkg::PSF_OP_CARRY:
         begin
            // Carry-only operations leave the other flags alone
            next_program_status_word[`PSF_BIT_CARRY] = alu_cy_i;
         end
         psf_pkg::PSF_OP_NONE:
         begin
         end
      endcase
      // Parity is not storage; it follows the accumulator in every enabled cycle,
      // which also makes a software write of bit 0 a no-op
      next_program_status_word[`PSF_BIT_PARITY] = ^acc_i;
   end

   // Status word register; enable low freezes it
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         program_status_word <= `PSF_RESET_VAL;
      end
      else if (ce_i)
      begin
         program_status_word <= next_program_status_word;
      end
   end

   // Output next values; bank base is the RAM address of the first
   // working register of the selected bank
   always_comb
   begin
      next_sfr_rdata = addr_hit ? next_program_status_word : `PSF_RDATA_IDLE;
      next_word_copy = next_program_status_word;
      next_bank_base = 5'(next_program_status_word[`PSF_BIT_BANK_HI:`PSF_BIT_BANK_LO])
                       << `PSF_BANK_SHIFT;
   end

   // Registered outputs; loaded from the next values, so reads show the word in step
   // with the status word register while every output comes straight from a flip-flop
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         sfr_rdata_o           <= `PSF_RDATA_IDLE;
         program_status_word_o <= `PSF_RESET_VAL;
         bank_base_o           <= `PSF_BASE_RESET;
      end
      else if (ce_i)
      begin
         sfr_rdata_o           <= next_sfr_rdata;
         program_status_word_o <= next_word_copy;
         bank_base_o           <= next_bank_base;
      end
   end

   // Flag strobes qualified by the enable, for the add/sub and mul/div classes only
   sequence s_addsub_upd;
      ce_i && alu_upd_i && alu_op_i == psf_pkg::PSF_OP_ADDSUB;
   endsequence

   sequence s_muldiv_upd;
      ce_i && alu_upd_i && alu_op_i == psf_pkg::PSF_OP_MULDIV;
   endsequence

   // A cycle in which software leaves the status word alone
   sequence s_no_sw_write;
      !(addr_hit && (sfr_wr_i || sfr_bit_wr_i));
   endsequence

   // Bank base follows the selector bits of the visible word
   chk_bank_base_map: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> bank_base_o ==
         (5'(program_status_word_o[`PSF_BIT_BANK_HI:`PSF_BIT_BANK_LO])
          << `PSF_BANK_SHIFT))
      else $error("bank base does not match selector");

   // Parity against the accumulator of the previous cycle
   chk_parity_track: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i |=> program_status_word_o[`PSF_BIT_PARITY] == ^$past(acc_i))
      else $error("parity flag wrong");

   // Arithmetic flag updates
   chk_carry_addsub: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      s_addsub_upd |=> program_status_word_o[`PSF_BIT_CARRY] == $past(alu_cy_i))
      else $error("carry flag not updated");

   chk_aux_addsub: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      s_addsub_upd |=> program_status_word_o[`PSF_BIT_AUX] == $past(alu_ac_i))
      else $error("aux carry flag not updated");

   chk_ov_update: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && alu_upd_i
      && alu_op_i inside {psf_pkg::PSF_OP_ADDSUB, psf_pkg::PSF_OP_MULDIV}
      |=> program_status_word_o[`PSF_BIT_OVFL] == $past(alu_ov_i))
      else $error("overflow flag not updated");

   chk_muldiv_clear: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      s_muldiv_upd |=> !program_status_word_o[`PSF_BIT_CARRY]
                       && !program_status_word_o[`PSF_BIT_AUX])
      else $error("carry flags not cleared by multiply or divide");

   // User flags move only on a software write
   chk_user_hold: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      s_no_sw_write |=> $stable({program_status_word_o[`PSF_BIT_USER0],
                                 program_status_word_o[`PSF_BIT_USER1]}))
      else $error("user flag changed without software");

   chk_bit_write: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && bit_wr && sfr_bit_sel_i inside {`PSF_BIT_USER0, `PSF_BIT_USER1}
      |=> program_status_word_o[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i))
      else $error("user flag bit write lost");

   // Software byte write of bits 7:1, and reads at another address
   chk_sfr_write: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && byte_wr && !alu_upd_i
      |=> program_status_word_o[7:1] == $past(sfr_wdata_i[7:1]))
      else $error("status word write lost");

   chk_unmapped_read: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !addr_hit |=> sfr_rdata_o == `PSF_RDATA_IDLE)
      else $error("read data shown for another address");

   // Parity follows a moving accumulator with one cycle of lag
   chk_parity_cycle: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && $changed(acc_i) ##1 ce_i
      |-> program_status_word_o[`PSF_BIT_PARITY] == ^$past(acc_i))
      else $error("parity lags accumulator");

endmodule // psf_flags
`default_nettype wire

// ---- dv/psw_alu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Arithmetic unit stand-in: one flag strobe per call
module psw_alu_model
(
   // Clock
   input  wire logic        clk_i,
   // Flag update toward the status word
   output logic                 upd_o,
   output var psf_pkg::psf_op_e op_o,
   output logic [2:0]           cav_o
);
   // Idle bus at start: no strobe and known qualifiers
   initial
   begin
      upd_o = 1'b0;
      op_o = psf_pkg::PSF_OP_NONE;
      cav_o = 3'h0;
   end
   // Strobe stands one edge only, then one idle edge before the next call
   task automatic fire(input psf_pkg::psf_op_e op, input logic [2:0] cav);
      op_o = op;
      cav_o = cav;
      upd_o = 1'b1;
      @(negedge clk_i);
      upd_o = 1'b0;
      @(negedge clk_i);
   endtask
endmodule // psw_alu_model
`default_nettype wire

// ---- dv/program_status_flags_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module program_status_flags_tb;
   logic             clk_i = 1'b0, resetn_i = 1'b0, ce = 1'b1, wr = 1'b0, bw = 1'b0;
   logic             bval = 1'b0, upd;
   logic [7:0]       addr = 8'hd0, wd = 8'h00, acc = 8'h00, rd, word;
   logic [4:0]       base;
   logic [2:0]       cav, bsel = 3'h0;
   psf_pkg::psf_op_e op;
   int               miscompares = 0, samples_checked = 0;
   // Rows: operation, conditions {carry,aux,overflow}, expected {carry,aux,overflow}
   typedef struct {psf_pkg::psf_op_e o; logic [2:0] c; logic [2:0] e;} psf_row_s;
   psf_row_s rows [6] = '{'{psf_pkg::PSF_OP_ADDSUB, 3'h7, 3'h7},
      '{psf_pkg::PSF_OP_CARRY, 3'h0, 3'h3}, '{psf_pkg::PSF_OP_MULDIV, 3'h5, 3'h1},
      '{psf_pkg::PSF_OP_ADDSUB, 3'h2, 3'h2}, '{psf_pkg::PSF_OP_NONE, 3'h5, 3'h2},
      '{psf_pkg::PSF_OP_CARRY, 3'h4, 3'h6}};
   always #10 clk_i = ~clk_i;
   psw_alu_model alu (.clk_i(clk_i), .upd_o(upd), .op_o(op), .cav_o(cav));
   psf_flags DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .sfr_addr_i(addr),
      .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_bit_wr_i(bw), .sfr_bit_sel_i(bsel),
      .sfr_bit_val_i(bval), .sfr_rdata_o(rd), .alu_upd_i(upd), .alu_op_i(op),
      .alu_cy_i(cav[2]), .alu_ac_i(cav[1]), .alu_ov_i(cav[0]), .acc_i(acc),
      .program_status_word_o(word), .bank_base_o(base));
   // Compare and count
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   // Byte write; strobe dropped after its edge, outputs settled a cycle on
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      @(negedge clk_i);
   endtask
   // Single-bit write, same pacing as the byte write
   task automatic bitw(input logic [2:0] s, input logic v);
      bsel = s;
      bval = v;
      bw = 1'b1;
      @(negedge clk_i);
      bw = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence, inputs moved on falling edges only
   initial
   begin
      repeat (16) @(negedge clk_i);
      chk("reset word", word, 8'h00);
      chk("reset base", {3'h0, base}, 8'h00);
      resetn_i = 1'b1;
      sw(8'hd0, 8'h23); // Bit 0 written high but acc parity is even
      chk("sw write", word, 8'h22);
      chk("sw read", rd, 8'h22);
      for (int i = 0; i < 6; i++)
      begin
         acc = 8'(i * 37);
         alu.fire(rows[i].o, rows[i].c);
         chk("alu flags", {5'h0, word[7:6], word[2]}, {5'h0, rows[i].e});
         chk("user flags", {6'h0, word[5], word[1]}, 8'h03);
         chk("parity", {7'h0, word[0]}, {7'h0, ^acc});
      end
      for (int b = 0; b < 4; b++)
      begin
         sw(8'hd0, 8'(b * 8));
         chk("bank base", {3'h0, base}, 8'(b * 8));
         chk("read back", rd, 8'(b * 8) | {7'h0, ^acc});
      end
      acc = 8'h01;
      @(negedge clk_i);
      @(negedge clk_i);
      chk("parity move", word, 8'h19);
      sw(8'hd1, 8'hff);
      chk("unmapped read", rd, 8'h00);
      chk("unmapped word", word, 8'h19);
      sw(8'hd0, 8'h20);
      bitw(3'h5, 1'b0);
      chk("bit clear", word, 8'h01);
      bitw(3'h1, 1'b1);
      chk("bit set", word, 8'h03);
      bitw(3'h0, 1'b0);
      chk("parity bit write", word, 8'h03);
      // Enable low: a write made while the enable is low never lands, even after it returns
      ce = 1'b0;
      sw(8'hd0, 8'hf8);
      chk("frozen word", word, 8'h03);
      ce = 1'b1;
      @(negedge clk_i);
      chk("thawed word", word, 8'h03);
      // Reset in mid-run clears everything, then parity returns
      sw(8'hd0, 8'h18);
      resetn_i = 1'b0;
      @(negedge clk_i);
      chk("midrun reset word", word, 8'h00);
      chk("midrun reset base", {3'h0, base}, 8'h00);
      resetn_i = 1'b1;
      @(negedge clk_i);
      chk("after reset parity", word, 8'h01);
      give_verdict();
   end
endmodule // program_status_flags_tb
`default_nettype wire
